// *** verilog/ptt_cfg.svh ***
// Constants of the transaction translator
`ifndef PTT_CFG_SVH
`define PTT_CFG_SVH
`define PTT_MRRS 512
`define PTT_MPS 256
`define PTT_CLS 64
`define PTT_MAX_OUT 8
`define PTT_USLOTS 16
`define PTT_DQ_DEPTH 8
`define PTT_4K 13'h1000
`define PTT_ADB 8'h80
`define PTT_ADB_MASK 7'h7F
`define PTT_RAM_WORDS 11'h600
`define PTT_RAM_BYTES 13'h1800
`define PTT_BE_FULL 4'hF
`define PTT_CMD_IORD 4'h2
`define PTT_CMD_IOWR 4'h3
`define PTT_CMD_MR 4'h6
`define PTT_CMD_MW 4'h7
`define PTT_CMD_CFGRD 4'hA
`define PTT_CMD_CFGWR 4'hB
`define PTT_CMD_MRM 4'hC
`define PTT_CMD_MRL 4'hE
`endif

// *** verilog/ptt_pkg.sv ***
// Types of the transaction translator
package ptt_pkg;
   typedef enum logic [3:0] {
      PTT_MWR, PTT_MSG, PTT_MSGD, PTT_IORD, PTT_IOWR, PTT_CFG0RD, PTT_CFG0WR,
      PTT_CFG1RD, PTT_CFG1WR, PTT_MRD, PTT_MRDLK
   } ptt_dkind_t;
   typedef struct packed {
      logic isRead;
      logic [31:0] addr;
      logic [12:0] count;
   } ptt_ureq_t;
   typedef struct packed {
      logic [31:0] data;
      logic [3:0] be;
      logic last;
   } ptt_ubeat_t;
   typedef struct packed {
      logic isRead;
      logic [31:0] addr;
      logic [12:0] len;
      logic [7:0] tag;
      logic [10:0] ramPtr;
   } ptt_utlp_t;
   typedef struct packed {
      logic [7:0] tag;
      logic [7:0] bytes;
   } ptt_ucpl_t;
   typedef struct packed {
      logic [3:0] slot;
      logic [7:0] bytes;
      logic last;
   } ptt_burst_t;
   typedef struct packed {
      ptt_dkind_t kind;
      logic [31:0] addr;
      logic [12:0] len;
      logic [15:0] reqId;
      logic intAssert;
   } ptt_dtlp_t;
   typedef struct packed {
      logic [3:0] cmd;
      logic cfgType1;
      logic [31:0] addr;
      logic [12:0] len;
      logic [2:0] slot;
   } ptt_pcmd_t;
   typedef struct packed {
      logic [2:0] slot;
      logic [12:0] bytes;
   } ptt_pdone_t;
   typedef struct packed {
      logic [15:0] reqId;
      logic ur;
   } ptt_dcpl_t;
endpackage : ptt_pkg

// *** verilog/ptt_chunk.sv ***
// Size of the next request piece
`include "ptt_cfg.svh"
module ptt_chunk
   import ptt_pkg::*;
(
   input wire logic [31:0] addr,
   input wire logic [12:0] remain,
   input wire logic [12:0] limit,
   output logic [12:0] len
);
   logic [12:0] toEdge;
   always_comb begin
      toEdge = `PTT_4K - {1'b0, addr[11:0]};
      len = remain;
      if (limit < len) begin
         len = limit;
      end
      if (toEdge < len) begin
         len = toEdge;
      end
   end
endmodule : ptt_chunk

// *** verilog/ptt_bridge.sv ***
// Transaction translator between PCI Express link and PCI/PCI-X bus
`include "ptt_cfg.svh"
// How it works
// - Small read: byte count becomes TLP length
// - Large read: pieces of read size, remainder last
// - Completions realigned, disconnect on each ADB
// - Two 64-byte completions form one 128-byte burst
// - No merging beyond the ADB
// - Split on payload, 4-KB edge, byte-enable holes
// - At most eight split reads outstanding
// - Posted writes held in central RAM
// - Byte-enable hole ends the current write TLP
// - Write TLPs never exceed payload size
// - Burst end sends TLP, no merging
// - Retry initiators when credit or RAM exhausted
// - Advertised credit is free central RAM
// - Downstream queued in arrival order
// - At most eight PCI transactions outstanding
// - Posted done when driven, no completion
// - Memory write forwarded, interrupt messages drive INTA
// - Repeat PCI transactions, then one completion
// - Up to eight non-posted requests concurrently
// - Type 0 and type 1 configuration map to same command
// - Locked read answered unsupported
// - Memory read picks read, line or multiple
module ptt_bridge
   import ptt_pkg::*;
#(
   parameter int MRRS = `PTT_MRRS,
   parameter int MPS = `PTT_MPS,
   parameter int CLS = `PTT_CLS,
   parameter int SPLIT_MAX = `PTT_MAX_OUT,
   parameter int PCI_MAX = `PTT_MAX_OUT,
   parameter bit MRM_EN = 1'b1
)(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic upReqValid,
   input wire ptt_ureq_t upReq,
   output logic upAccept,
   output logic upRetry,
   input wire logic upBeatValid,
   input wire ptt_ubeat_t upBeat,
   output logic upBeatReady,
   input wire logic [7:0] postCredit,
   input wire logic linkFree,
   input wire logic [10:0] linkFreeWords,
   output logic utlpValid,
   output ptt_utlp_t utlp,
   input wire logic [10:0] ramRdAddr,
   output logic [31:0] ramRdData,
   input wire logic ucplValid,
   input wire ptt_ucpl_t ucpl,
   output logic burstValid,
   output ptt_burst_t burst,
   input wire logic dtlpValid,
   input wire ptt_dtlp_t dtlp,
   output logic dtlpReady,
   output logic [12:0] dsCredit,
   output logic pcmdValid,
   output ptt_pcmd_t pcmd,
   input wire logic pdoneValid,
   input wire ptt_pdone_t pdone,
   output logic dcplValid,
   output ptt_dcpl_t dcpl,
   output logic intA
);
   localparam int NS = `PTT_USLOTS;
   localparam int QD = `PTT_DQ_DEPTH;
   localparam logic [12:0] MPSW = 13'(MPS / 4);

   if (MPS % 4 != 0 || MPS > 4096 || MRRS > 4096 || MRRS < 4 || SPLIT_MAX > NS ||
      PCI_MAX > 8 || CLS < 4 || (CLS & (CLS - 1)) != 0) begin : gBad
      $error("ptt_bridge: unsupported parameter value");
   end

   // First clear bit of a busy mask
   function automatic logic [4:0] firstFree(input logic [15:0] busy);
      firstFree = 5'h10;
      for (int i = 15; i >= 0; i--) begin
         if (!busy[i]) begin
            firstFree = 5'(i);
         end
      end
   endfunction : firstFree

   function automatic logic [3:0] cmdOf(input ptt_dtlp_t t);
      logic [12:0] lineOff;
      lineOff = 13'(t.addr) & 13'(CLS - 1);
      case (t.kind)
         PTT_IORD: cmdOf = `PTT_CMD_IORD;
         PTT_IOWR: cmdOf = `PTT_CMD_IOWR;
         PTT_CFG0RD, PTT_CFG1RD: cmdOf = `PTT_CMD_CFGRD;
         PTT_CFG0WR, PTT_CFG1WR: cmdOf = `PTT_CMD_CFGWR;
         PTT_MRD: begin
            if (lineOff + t.len <= 13'(CLS) && t.len < 13'(CLS)) begin
               cmdOf = `PTT_CMD_MR;
            end else if (t.len < 13'(2 * CLS) || !MRM_EN) begin
               cmdOf = `PTT_CMD_MRL;
            end else begin
               cmdOf = `PTT_CMD_MRM;
            end
         end
         default: cmdOf = `PTT_CMD_MW;
      endcase
   endfunction : cmdOf

   // Upstream request side
   typedef enum {UP_IDLE, UP_RD, UP_WR} ptt_upst_t;
   ptt_upst_t upState;
   logic [31:0] rdAddr, segAddr;
   logic [12:0] rdRemain, chunkLen, segBeats;
   logic [3:0] rdSlot, tagSeq;
   logic [10:0] wrPtr, segPtr, usedWords;
   logic [15:0] slotBusy, slotSplit;
   logic [12:0] slotRemain [NS];
   logic [7:0] slotAcc [NS];
   logic [7:0] slotTgt [NS];
   logic [4:0] freeSlot;
   logic [4:0] splitCnt;
   logic [31:0] ram [`PTT_RAM_WORDS];
   logic reqSeen, needSplit, rdAlloc, wrOk, beatTake, segClose;
   logic [31:0] beatNext;

   ptt_chunk uChunk (
      .addr(upState == UP_IDLE ? upReq.addr : rdAddr),
      .remain(upState == UP_IDLE ? upReq.count : rdRemain),
      .limit(13'(MRRS)),
      .len(chunkLen)
   );

   always_comb begin
      freeSlot = firstFree(slotBusy);
      reqSeen = upState == UP_IDLE && upReqValid && !upAccept && !upRetry;
      needSplit = chunkLen != upReq.count;
      rdAlloc = reqSeen && upReq.isRead && !freeSlot[4] &&
         !(needSplit && splitCnt >= 5'(SPLIT_MAX));
      wrOk = postCredit != 8'h00 && (`PTT_RAM_WORDS - usedWords) >= 11'(MPSW);
      beatTake = upBeatValid && upBeatReady;
      beatNext = segAddr + {17'h0, segBeats + 13'h1, 2'b00};
      segClose = upBeat.last || segBeats + 13'h1 == MPSW ||
         (upBeat.be != `PTT_BE_FULL && segBeats != 13'h0) ||
         beatNext[11:0] == 12'h000;
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         upState <= UP_IDLE;
         upAccept <= 1'b0;
         upRetry <= 1'b0;
         utlpValid <= 1'b0;
         utlp <= '0;
         rdAddr <= '0;
         rdRemain <= '0;
         rdSlot <= '0;
         tagSeq <= '0;
         segAddr <= '0;
         segPtr <= '0;
         segBeats <= '0;
         upBeatReady <= 1'b0;
      end else begin
         upAccept <= 1'b0;
         upRetry <= 1'b0;
         utlpValid <= 1'b0;
         case (upState)
            UP_IDLE: begin
               if (reqSeen && upReq.isRead) begin
                  upAccept <= rdAlloc;
                  upRetry <= !rdAlloc;
                  if (rdAlloc) begin
                     rdAddr <= upReq.addr;
                     rdRemain <= upReq.count;
                     rdSlot <= freeSlot[3:0];
                     upState <= UP_RD;
                  end
               end else if (reqSeen) begin
                  upAccept <= wrOk;
                  upRetry <= !wrOk;
                  if (wrOk) begin
                     segAddr <= upReq.addr;
                     segBeats <= '0;
                     segPtr <= wrPtr;
                     upBeatReady <= 1'b1;
                     upState <= UP_WR;
                  end
               end
            end
            UP_RD: begin
               utlpValid <= 1'b1;
               utlp <= '{1'b1, rdAddr, chunkLen, {tagSeq, rdSlot}, 11'h000};
               tagSeq <= tagSeq + 4'h1;
               rdAddr <= rdAddr + {19'h0, chunkLen};
               rdRemain <= rdRemain - chunkLen;
               if (rdRemain == chunkLen) begin
                  upState <= UP_IDLE;
               end
            end
            default: begin
               upBeatReady <= (`PTT_RAM_WORDS - usedWords) > 11'h2 &&
                  !(beatTake && upBeat.last);
               if (beatTake) begin
                  segBeats <= segBeats + 13'h1;
                  if (segClose) begin
                     utlpValid <= 1'b1;
                     utlp <= '{1'b0, segAddr, 13'({segBeats + 13'h1, 2'b00}), {tagSeq, 4'h0},
                        segPtr};
                     tagSeq <= tagSeq + 4'h1;
                     segAddr <= beatNext;
                     segBeats <= '0;
                     segPtr <= wrPtr == `PTT_RAM_WORDS - 11'h1 ? 11'h000 : wrPtr + 11'h1;
                     if (upBeat.last) begin
                        upState <= UP_IDLE;
                     end
                  end
               end
            end
         endcase
      end
   end

   // Central RAM for posted upstream writes
   always_ff @(posedge ref_clk) begin
      if (beatTake) begin
         ram[wrPtr] <= upBeat.data;
      end
      ramRdData <= ram[ramRdAddr];
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         wrPtr <= '0;
         usedWords <= '0;
      end else begin
         if (beatTake) begin
            wrPtr <= wrPtr == `PTT_RAM_WORDS - 11'h1 ? 11'h000 : wrPtr + 11'h1;
         end
         usedWords <= usedWords + {10'h0, beatTake} - (linkFree ? linkFreeWords : 11'h0);
      end
   end

   // Read records and completion realignment
   logic [3:0] cs;
   logic [8:0] cSum;
   logic cDone, cEmit;
   always_comb begin
      cs = ucpl.tag[3:0];
      cSum = {1'b0, slotAcc[cs]} + {1'b0, ucpl.bytes};
      cDone = slotRemain[cs] == {5'h0, ucpl.bytes};
      cEmit = cSum >= {1'b0, slotTgt[cs]} || cDone;
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         slotBusy <= '0;
         slotSplit <= '0;
         splitCnt <= '0;
         burstValid <= 1'b0;
         burst <= '0;
         for (int i = 0; i < NS; i++) begin
            slotRemain[i] <= '0;
            slotAcc[i] <= '0;
            slotTgt[i] <= '0;
         end
      end else begin
         burstValid <= 1'b0;
         splitCnt <= splitCnt + 5'(rdAlloc && needSplit) -
            5'(ucplValid && cDone && slotSplit[cs]);
         if (ucplValid) begin
            slotRemain[cs] <= slotRemain[cs] - {5'h0, ucpl.bytes};
            slotAcc[cs] <= cEmit ? 8'h00 : cSum[7:0];
            if (cEmit) begin
               burstValid <= 1'b1;
               burst <= '{cs, cSum[7:0], cDone};
               slotTgt[cs] <= `PTT_ADB;
            end
            if (cDone) begin
               slotBusy[cs] <= 1'b0;
            end
         end
         if (rdAlloc) begin
            slotBusy[freeSlot[3:0]] <= 1'b1;
            slotSplit[freeSlot[3:0]] <= needSplit;
            slotRemain[freeSlot[3:0]] <= upReq.count;
            slotAcc[freeSlot[3:0]] <= '0;
            slotTgt[freeSlot[3:0]] <= `PTT_ADB - {1'b0, upReq.addr[6:0] & `PTT_ADB_MASK};
         end
      end
   end

   // Downstream queue, credit and PCI issue
   ptt_dtlp_t dq [QD];
   ptt_dtlp_t h;
   logic [2:0] qHead, qTail;
   logic [3:0] qCount, dsOut;
   logic [12:0] dsUsed, relLen;
   logic [7:0] dBusy, dNp;
   logic [12:0] dRemain [8];
   logic [12:0] dLen [8];
   logic [31:0] dAddr [8];
   logic [15:0] dReq [8];
   ptt_pcmd_t dCmd [8];
   logic [4:0] dFree;
   logic take, pop, popSlot, pDone, rel;

   always_comb begin
      h = dq[qHead];
      dFree = firstFree({8'hFF, dBusy});
      popSlot = h.kind != PTT_MRDLK && h.kind != PTT_MSG && h.kind != PTT_MSGD;
      take = dtlpValid && dtlpReady;
      pop = qCount != 4'h0 && !pdoneValid &&
         !(popSlot && (dsOut >= 4'(PCI_MAX) || dFree[4]));
      pDone = pdoneValid && dRemain[pdone.slot] == pdone.bytes;
      rel = (pop && !popSlot) || pDone;
      relLen = pDone ? dLen[pdone.slot] : h.len;
   end

   always_ff @(posedge ref_clk) begin
      if (take) begin
         dq[qTail] <= dtlp;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         qHead <= '0;
         qTail <= '0;
         qCount <= '0;
         dsUsed <= '0;
         dtlpReady <= 1'b0;
         dsCredit <= '0;
      end else begin
         qTail <= qTail + 3'(take);
         qHead <= qHead + 3'(pop);
         qCount <= qCount + 4'(take) - 4'(pop);
         dsUsed <= dsUsed + (take ? dtlp.len : 13'h0) - (rel ? relLen : 13'h0);
         dsCredit <= `PTT_RAM_BYTES - dsUsed;
         dtlpReady <= qCount + 4'(take) < 4'(QD - 1) && dsUsed < `PTT_RAM_BYTES;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         dBusy <= '0;
         dNp <= '0;
         dsOut <= '0;
         pcmdValid <= 1'b0;
         pcmd <= '0;
         dcplValid <= 1'b0;
         dcpl <= '0;
         intA <= 1'b0;
         for (int i = 0; i < 8; i++) begin
            dRemain[i] <= '0;
            dLen[i] <= '0;
            dAddr[i] <= '0;
            dReq[i] <= '0;
            dCmd[i] <= '0;
         end
      end else begin
         pcmdValid <= 1'b0;
         dcplValid <= 1'b0;
         dsOut <= dsOut + 4'(pop && popSlot) - 4'(pDone);
         if (pdoneValid && pDone) begin
            dBusy[pdone.slot] <= 1'b0;
            dcplValid <= dNp[pdone.slot];
            dcpl <= '{dReq[pdone.slot], 1'b0};
         end else if (pdoneValid) begin
            dRemain[pdone.slot] <= dRemain[pdone.slot] - pdone.bytes;
            dAddr[pdone.slot] <= dAddr[pdone.slot] + {19'h0, pdone.bytes};
            pcmdValid <= 1'b1;
            pcmd <= '{dCmd[pdone.slot].cmd, dCmd[pdone.slot].cfgType1,
               dAddr[pdone.slot] + {19'h0, pdone.bytes},
               dRemain[pdone.slot] - pdone.bytes, pdone.slot};
         end else if (pop) begin
            case (h.kind)
               PTT_MRDLK: begin
                  dcplValid <= 1'b1;
                  dcpl <= '{h.reqId, 1'b1};
               end
               PTT_MSG: intA <= h.intAssert;
               PTT_MSGD: intA <= intA;
               default: begin
                  dBusy[dFree[2:0]] <= 1'b1;
                  dNp[dFree[2:0]] <= h.kind != PTT_MWR;
                  dRemain[dFree[2:0]] <= h.len;
                  dLen[dFree[2:0]] <= h.len;
                  dAddr[dFree[2:0]] <= h.addr;
                  dReq[dFree[2:0]] <= h.reqId;
                  dCmd[dFree[2:0]] <= '{cmdOf(h), h.kind == PTT_CFG1RD || h.kind == PTT_CFG1WR,
                     h.addr, h.len, dFree[2:0]};
                  pcmdValid <= 1'b1;
                  pcmd <= '{cmdOf(h), h.kind == PTT_CFG1RD || h.kind == PTT_CFG1WR,
                     h.addr, h.len, dFree[2:0]};
               end
            endcase
         end
      end
   end
endmodule : ptt_bridge

// *** testbench/ptt_bridge_assertions.sv ***
// Port checker of the transaction translator
module ptt_bridge_assertions
   import ptt_pkg::*;
#(
   parameter int MRRS = 512,
   parameter int MPS = 256
)(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic upReqValid,
   input wire ptt_ureq_t upReq,
   input wire logic upAccept,
   input wire logic upRetry,
   input wire logic [7:0] postCredit,
   input wire logic utlpValid,
   input wire ptt_utlp_t utlp,
   input wire logic burstValid,
   input wire ptt_burst_t burst,
   input wire logic [12:0] dsCredit,
   input wire logic pcmdValid,
   input wire ptt_pcmd_t pcmd,
   input wire logic pdoneValid,
   input wire logic dcplValid,
   input wire ptt_dcpl_t dcpl
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   property p_answer;
      (upAccept || upRetry) |-> $past(upReqValid) && !(upAccept && upRetry);
   endproperty
   a_answer: assert property (p_answer) else $error("bad request answer");
   property p_credit;
      upAccept && !$past(upReq.isRead) |-> $past(postCredit) != 8'h00;
   endproperty
   a_credit: assert property (p_credit) else $error("write taken without credit");
   property p_rdstart;
      upAccept && $past(upReq.isRead) |=> utlpValid && utlp.isRead;
   endproperty
   a_rdstart: assert property (p_rdstart) else $error("read header late");
   property p_rdlen;
      utlpValid && utlp.isRead |-> utlp.len != 13'h0 && utlp.len <= MRRS;
   endproperty
   a_rdlen: assert property (p_rdlen) else $error("read piece size");
   property p_wrlen;
      utlpValid && !utlp.isRead |-> utlp.len <= MPS && utlp.len[1:0] == 2'b00;
   endproperty
   a_wrlen: assert property (p_wrlen) else $error("write piece size");
   property p_edge;
      utlpValid |-> {2'b00, utlp.addr[11:0]} + {1'b0, utlp.len} <= 14'h1000;
   endproperty
   a_edge: assert property (p_edge) else $error("piece crosses 4K");
   property p_burst;
      burstValid |-> burst.bytes != 8'h00 && burst.bytes <= 8'h80;
   endproperty
   a_burst: assert property (p_burst) else $error("burst size");
   property p_ds;
      dsCredit <= 13'h1800;
   endproperty
   a_ds: assert property (p_ds) else $error("credit above RAM");
   property p_done;
      dcplValid && !dcpl.ur |-> $past(pdoneValid);
   endproperty
   a_done: assert property (p_done) else $error("completion before data");
   property p_cmd;
      pcmdValid |-> pcmd.cmd inside {4'h2, 4'h3, 4'h6, 4'h7, 4'hA, 4'hB, 4'hC, 4'hE};
   endproperty
   a_cmd: assert property (p_cmd) else $error("bad bus command");
endmodule : ptt_bridge_assertions

bind ptt_bridge ptt_bridge_assertions #(.MRRS(MRRS), .MPS(MPS)) i_ptt_bridge_assertions (
   .ref_clk, .reset, .upReqValid, .upReq, .upAccept, .upRetry, .postCredit, .utlpValid,
   .utlp, .burstValid, .burst, .dsCredit, .pcmdValid, .pcmd, .pdoneValid, .dcplValid, .dcpl
);

// *** testbench/ptt_pci_agent.sv ***
// PCI bus agent model answering issued transactions
module ptt_pci_agent
   import ptt_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic halve,
   input wire logic pcmdValid,
   input wire ptt_pcmd_t pcmd,
   output logic pdoneValid,
   output ptt_pdone_t pdone
);
   timeunit 1ns;
   timeprecision 1ns;
   ptt_pcmd_t q[$];
   int n = 0;
   initial pdoneValid = 1'b0;
   initial pdone = '0;
   always @(posedge ref_clk) begin
      pdoneValid <= 1'b0;
      pdone <= ~pdone;
      if (pcmdValid === 1'b1) q.push_back(pcmd);
      if (reset) q.delete();
      else if (q.size() > 0 && ++n == 3) begin
         n = 0;
         pdoneValid <= 1'b1;
         pdone <= '{q[0].slot, (halve && q[0].len > 13'h4) ? q[0].len >> 1 : q[0].len};
         void'(q.pop_front());
      end
   end
endmodule : ptt_pci_agent

// *** testbench/ptt_bridge_bench.sv ***
// Self-checking bench of the transaction translator
module ptt_bridge_bench;
   import ptt_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 1'b0, reset = 1'b1, upReqValid, upAccept, upRetry, upBeatValid, upBeatReady;
   logic linkFree, utlpValid, ucplValid, burstValid, dtlpValid, dtlpReady, pcmdValid;
   logic pdoneValid, dcplValid, intA, halve;
   logic [7:0] postCredit;
   logic [10:0] linkFreeWords, ramRdAddr;
   logic [31:0] ramRdData;
   logic [12:0] dsCredit;
   ptt_ureq_t upReq;
   ptt_ubeat_t upBeat;
   ptt_utlp_t utlp, ut[$];
   ptt_ucpl_t ucpl;
   ptt_burst_t burst, bq[$];
   ptt_dtlp_t dtlp;
   ptt_pcmd_t pcmd, pq[$];
   ptt_pdone_t pdone;
   ptt_dcpl_t dcpl, dq[$];
   int err_total = 0, total_checks = 0, cyc = 0;
   ptt_bridge i_ptt_bridge (.ref_clk, .reset, .upReqValid, .upReq, .upAccept, .upRetry,
      .upBeatValid, .upBeat, .upBeatReady, .postCredit, .linkFree, .linkFreeWords, .utlpValid,
      .utlp, .ramRdAddr, .ramRdData, .ucplValid, .ucpl, .burstValid, .burst,
      .dtlpValid, .dtlp, .dtlpReady, .dsCredit, .pcmdValid, .pcmd, .pdoneValid, .pdone,
      .dcplValid, .dcpl, .intA);
   ptt_pci_agent i_ptt_pci_agent (.ref_clk, .reset, .halve, .pcmdValid, .pcmd, .pdoneValid,
      .pdone);
   initial forever #20 ref_clk = ~ref_clk;
   always @(negedge ref_clk) begin
      if (utlpValid === 1'b1) ut.push_back(utlp);
      if (burstValid === 1'b1) bq.push_back(burst);
      if (pcmdValid === 1'b1) pq.push_back(pcmd);
      if (dcplValid === 1'b1) dq.push_back(dcpl);
      if (++cyc == 5000) begin
         err_total++;
         end_sim();
      end
   end
   task automatic end_sim;
      $display("Counts: checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t got %0h expected %0h", $time, got, exp);
      end
   endtask : chk
   // Waits until outputs have been idle for ten cycles
   task automatic quiet;
      int idle = 0;
      int k = 0;
      while (idle < 10 && k < 300) begin
         @(negedge ref_clk);
         k++;
         idle = ((utlpValid | burstValid | pcmdValid | dcplValid) === 1'b1) ? 0 : idle + 1;
      end
   endtask : quiet
   task automatic req(input logic rd, input logic [31:0] a, input logic [12:0] n,
         output logic acc);
      int k = 0;
      ut.delete();
      upReq = '{rd, a, n};
      upReqValid = 1'b1;
      do begin
         @(negedge ref_clk);
         k++;
      end while (upAccept !== 1'b1 && upRetry !== 1'b1 && k < 20);
      acc = upAccept;
      upReqValid = 1'b0;
   endtask : req
   task automatic t_read;
      logic acc;
      bq.delete();
      req(1'b1, 32'h0, 13'h100, acc);
      quiet();
      chk(acc, 1'b1);
      chk(ut.size(), 1);
      chk(ut[0].len, 13'h100);
      ucpl = '{ut[0].tag, 8'h40};
      ucplValid = 1'b1;
      repeat (4) @(negedge ref_clk);
      ucplValid = 1'b0;
      quiet();
      chk(bq.size(), 2);
      chk(bq[0].bytes, 8'h80);
      chk(bq[0].slot, ut[0].tag[3:0]);
      chk(bq[1].last, 1'b1);
      $display("test read done");
   endtask : t_read
   task automatic t_split(input logic [31:0] a, input logic [12:0] n, l0, l1);
      logic acc;
      req(1'b1, a, n, acc);
      quiet();
      chk(acc, 1'b1);
      chk(ut.size(), 2);
      chk(ut[0].len, l0);
      chk(ut[1].len, l1);
      chk(ut[1].addr, a + l0);
      chk(ut[0].tag != ut[1].tag, 1'b1);
      $display("test split done");
   endtask : t_split
   task automatic t_limit;
      logic acc;
      for (int i = 0; i < 7; i++) begin
         req(1'b1, 32'h10000 * (i + 1), 13'h400, acc);
         quiet();
         chk(acc, i < 6);
      end
      req(1'b1, 32'h0, 13'h40, acc);
      quiet();
      chk(acc, 1'b1);
      $display("test limit done");
   endtask : t_limit
   task automatic t_write(input int nb, input int hole, input int en);
      logic acc;
      int s = 0;
      req(1'b0, 32'h2000, 13'(nb * 4), acc);
      for (int i = 0; i < nb; i++) begin
         while (upBeatReady !== 1'b1) @(negedge ref_clk);
         upBeat = '{32'(i), (i == hole) ? 4'h3 : 4'hF, i == nb - 1};
         upBeatValid = 1'b1;
         @(negedge ref_clk);
      end
      upBeatValid = 1'b0;
      quiet();
      foreach (ut[i]) s += ut[i].len;
      chk(acc, 1'b1);
      chk(ut.size(), en);
      chk(s, nb * 4);
      // Last word of the last piece holds the final beat
      ramRdAddr = 11'(ut[ut.size() - 1].ramPtr + ut[ut.size() - 1].len / 4 - 1);
      @(negedge ref_clk);
      chk(ramRdData, nb - 1);
      $display("test write done");
   endtask : t_write
   task automatic t_retry;
      logic acc;
      postCredit = 8'h00;
      req(1'b0, 32'h3000, 13'h4, acc);
      chk(acc, 1'b0);
      linkFree = 1'b1;
      linkFreeWords = 11'h057;
      @(negedge ref_clk);
      linkFree = 1'b0;
      postCredit = 8'h10;
      t_write(1, -1, 1);
      $display("test retry done");
   endtask : t_retry
   task automatic t_down(input ptt_dkind_t kd, input logic [12:0] ln, input logic [3:0] cmd,
         input logic t1, input int npc, input logic np, input logic ur);
      pq.delete();
      dq.delete();
      while (dtlpReady !== 1'b1) @(negedge ref_clk);
      dtlp = '{kd, 32'h100, ln, 16'h0123, 1'b1};
      dtlpValid = 1'b1;
      @(negedge ref_clk);
      dtlpValid = 1'b0;
      quiet();
      chk(pq.size(), npc);
      if (npc > 0) begin
         chk(pq[0].cmd, cmd);
         chk(pq[0].cfgType1, t1);
      end
      chk(dq.size(), np);
      if (np) chk(dq[0].ur, ur);
      $display("test downstream done");
   endtask : t_down
   initial begin
      {upReqValid, upBeatValid, linkFree, ucplValid, dtlpValid, halve} = '0;
      {upReq, upBeat, ucpl, dtlp, linkFreeWords, ramRdAddr} = '0;
      postCredit = 8'h10;
      repeat (4) @(negedge ref_clk);
      reset = 1'b0;
      repeat (2) @(negedge ref_clk);
      chk(dtlpReady, 1'b1);
      chk(dsCredit, 13'h1800);
      t_read();
      t_split(32'h0, 13'h400, 13'h200, 13'h200);
      t_split(32'hF00, 13'h200, 13'h100, 13'h100);
      t_limit();
      t_write(3, -1, 1);
      t_write(80, -1, 2);
      t_write(4, 2, 2);
      t_retry();
      t_down(PTT_IORD, 13'h4, 4'h2, 1'b0, 1, 1'b1, 1'b0);
      t_down(PTT_IOWR, 13'h4, 4'h3, 1'b0, 1, 1'b1, 1'b0);
      t_down(PTT_CFG0RD, 13'h4, 4'hA, 1'b0, 1, 1'b1, 1'b0);
      t_down(PTT_CFG0WR, 13'h4, 4'hB, 1'b0, 1, 1'b1, 1'b0);
      t_down(PTT_CFG1RD, 13'h4, 4'hA, 1'b1, 1, 1'b1, 1'b0);
      t_down(PTT_CFG1WR, 13'h4, 4'hB, 1'b1, 1, 1'b1, 1'b0);
      t_down(PTT_MRD, 13'h4, 4'h6, 1'b0, 1, 1'b1, 1'b0);
      t_down(PTT_MRD, 13'h40, 4'hE, 1'b0, 1, 1'b1, 1'b0);
      t_down(PTT_MRD, 13'h80, 4'hC, 1'b0, 1, 1'b1, 1'b0);
      t_down(PTT_MRDLK, 13'h4, 4'h0, 1'b0, 0, 1'b1, 1'b1);
      t_down(PTT_MWR, 13'h4, 4'h7, 1'b0, 1, 1'b0, 1'b0);
      t_down(PTT_MSG, 13'h0, 4'h0, 1'b0, 0, 1'b0, 1'b0);
      chk(intA, 1'b1);
      t_down(PTT_MSGD, 13'h4, 4'h0, 1'b0, 0, 1'b0, 1'b0);
      halve = 1'b1;
      t_down(PTT_MRD, 13'h8, 4'h6, 1'b0, 2, 1'b1, 1'b0);
      halve = 1'b0;
      end_sim();
   end
endmodule : ptt_bridge_bench
